// File: design/sacs_pkg.sv
// constants for the conversion sequencer
package sacs_pkg;
  // register indices (byte addresses)
  localparam logic [2:0] SACS_CTRL = 3'h0;
  localparam logic [2:0] SACS_CFG  = 3'h1;
  localparam logic [2:0] SACS_ACC  = 3'h2;
  localparam logic [2:0] SACS_TIME = 3'h3;
  localparam logic [2:0] SACS_RESH = 3'h4;
  localparam logic [2:0] SACS_RESL = 3'h5;
  localparam logic [2:0] SACS_WGT  = 3'h6;
  localparam logic [2:0] SACS_WLT  = 3'h7;
  // control register fields
  localparam int SACS_B_EN    = 7;
  localparam int SACS_B_BURST = 6;
  localparam int SACS_B_DONE  = 5;
  localparam int SACS_B_BUSY  = 4;
  localparam int SACS_B_WIN   = 3;
  // config register fields
  localparam int SACS_B_EIGHT = 2;
  localparam int SACS_B_LPTRK = 1;
  localparam int SACS_B_GAIN  = 0;
  // accumulator register fields
  localparam int SACS_B_DIE   = 7;
  localparam int SACS_B_WIE   = 6;
  // start sources
  localparam logic [2:0] SACS_SRC_SW  = 3'h0;
  localparam logic [2:0] SACS_SRC_T0  = 3'h1;
  localparam logic [2:0] SACS_SRC_T2  = 3'h2;
  localparam logic [2:0] SACS_SRC_T3  = 3'h3;
  localparam logic [2:0] SACS_SRC_EXT = 3'h4;
  // timing and widths
  localparam logic [5:0] SACS_LP_TRACK = 6'h02; // three conversion clocks
  localparam logic [3:0] SACS_MSB      = 4'h9;
  localparam logic [3:0] SACS_LSB10    = 4'h0;
  localparam logic [3:0] SACS_LSB8     = 4'h2;
  localparam logic [9:0] SACS_SAR_INIT = 10'h200;
  localparam logic [4:0] SACS_DIV_RST  = 5'h1f;
  localparam logic [7:0] SACS_TIME_RST = 8'h11;
  // sequencer states, gray along the usual path
  typedef enum logic [2:0] {
    SACS_IDLE  = 3'b000,
    SACS_PWRUP = 3'b001,
    SACS_TRACK = 3'b011,
    SACS_LPTRK = 3'b010,
    SACS_CONV  = 3'b110
  } sacs_state_t;
endpackage

// File: design/sacs_sequencer.sv
// sar converter start, track, convert and burst sequencer
//
// Behaviour
// - conversion clock divides system clock, or burst oscillator when burst mode on
// - three-bit start source picks software, three timers, or external pin (100)
// - writing one to busy starts; busy reads one until conversion completes
// - busy falling edge that ends the repeat count sets done flag and raises enabled interrupt
// - result registers valid whenever done flag reads one
// - timer 2/3 use low overflow in 8-bit mode, high in 16-bit mode
// - external source starts conversion on rising edge of start pin
// - normal tracking continuous except during conversion, burst off
// - low-power tracking adds 3 conversion clocks after start event
// - low-power tracking with pin: track while pin low, convert on rise
// - no tracking in standby or sleep
// - burst wakes converter, runs repeat conversions on oscillator, powers down
// - burst runs from oscillator independent of system clock; here its edges are one-cycle enables on the system clock
// - in burst mode enable bit selects idle power state
// - powered-down converter waits power-up time; enabled one starts at once
// - burst: one start runs repeat count; else one start per conversion
// - done flag set only after full repeat count accumulated
// - window compare only after full repeat count accumulated
// - burst tracking from time settings, plus 3 clocks when low-power tracking
// - 8-bit mode: two fewer clocks, low bits 00, low result reads 0x00
// - repeat count field picks 1..64; sums kept unsigned
// - done flag set by hardware only, cleared only by software
`timescale 1ns/1ns
module sacs_sequencer (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       ce_in,
  input  wire logic [2:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  input  wire logic       timer0_ovf_in,
  input  wire logic       timer2_low_ovf_in,
  input  wire logic       timer2_high_ovf_in,
  input  wire logic       timer2_split_in,
  input  wire logic       timer3_low_ovf_in,
  input  wire logic       timer3_high_ovf_in,
  input  wire logic       timer3_split_in,
  input  wire logic       ext_conv_start_in,
  input  wire logic       standby_in,
  input  wire logic       burst_osc_tick_in,
  input  wire logic       sar_cmp_in,
  output logic      [9:0] dac_code_out,
  output logic            track_out,
  output logic            convert_out,
  output logic            power_out,
  output logic            input_gain_select_out,
  output logic            irq_out
);
  import sacs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // register map, by byte index
  // 0 control: [7] enable, [6] burst, [5] done flag, [4] busy or start,
  //   [3] window flag, [2:0] start source
  // 1 config: [7:3] clock divider, [2] eight-bit, [1] low-power track,
  //   [0] gain select
  // 2 accumulator: [7] done irq enable, [6] window irq enable,
  //   [2:0] repeat code, 0 gives 1 and 1 to 5 give 4 to 64
  // 3 timing: [7:4] power-up ticks minus one, [3:0] track ticks minus one
  // 4 and 5: result sum high and low bytes, read only
  // 6 and 7: window upper and lower limits on the high result byte
  //
  // start sources: 0 software, 1 timer 0, 2 timer 2, 3 timer 3, 4 pin
  // timers 2 and 3 in split mode hand over their low-byte overflow
  // the pin starts on a rising edge against last cycle's level,
  //   so a pin already high when its source is picked is no edge
  //
  // conversion clock: one tick every divider plus one enables
  // enables are every system clock, or burst oscillator edges in burst mode
  // non-burst, low-power track off: start goes straight to converting
  // non-burst, low-power track on: three ticks of tracking come first,
  //   except with the pin, where the low time of the pin is the tracking
  // burst: power-up if disabled, track, low-power track if on, convert,
  //   then back to track until the repeat count is reached
  // eight-bit mode stops the trials two bits early, low bits stay zero
  //
  // writing zero to done or window flag clears it, writing one keeps it
  // a completing conversion sets the flags after any clear in that cycle,
  //   so software never loses a completion it has not seen yet
  // start events outside idle are dropped, keeping a sum in progress safe
  // busy falls in the same cycle as done rises
  //
  // tracking stops in standby whatever the mode
  // power follows enable; in burst mode a disabled converter is powered
  //   only from the start event until the burst ends
  //
  // limitations:
  // burst oscillator edges arrive as one-cycle enables on the system clock,
  //   so a burst here lasts many system clocks, not a fraction of one
  // the low result byte reads zero in eight-bit mode, the sum stays full
  // window compare looks at the high byte only, flagging outside the limits
  // starts in burst mode must wait until the burst ends and busy reads zero;
  //   closer ones fall inside the burst and are dropped

  typedef struct packed {
    // sequencer working state
    sacs_state_t st;
    logic [4:0]  div;
    logic [5:0]  cnt;
    logic [3:0]  bitn;
    logic [9:0]  sar;
    logic [15:0] acc;
    logic [6:0]  rep;
    logic        ext_prev;
    // software-visible control and config
    logic        en;
    logic        burst;
    logic        done;
    logic        busy;
    logic        winf;
    logic [2:0]  sel;
    logic [4:0]  divider;
    logic        eightb;
    logic        lptrk;
    logic        gain;
    logic [2:0]  repsel;
    logic        die;
    logic        wie;
    logic [3:0]  pwr;
    logic [3:0]  trk;
    // results, window limits and read data
    logic [7:0]  resh;
    logic [7:0]  resl;
    logic [7:0]  gt;
    logic [7:0]  lt;
    logic [7:0]  rdata;
    // registered analog and interrupt outputs
    logic        track;
    logic        conv;
    logic        power;
    logic        irq;
  } sacs_regs_t;

  sacs_regs_t q;
  sacs_regs_t d;

  // repeat field code to conversion count
  function automatic logic [6:0] sacs_target(input logic [2:0] code);
    case (code)
      3'h1:    sacs_target = 7'h04;
      3'h2:    sacs_target = 7'h08;
      3'h3:    sacs_target = 7'h10;
      3'h4:    sacs_target = 7'h20;
      3'h5:    sacs_target = 7'h40;
      default: sacs_target = 7'h01;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic       tick;
    logic       start;
    logic [9:0] sample;
    logic [6:0] rep_n;
    logic [3:0] last;
    tick   = 1'b0;
    start  = 1'b0;
    sample = 10'h000;
    rep_n  = 7'h00;
    last   = 4'h0;
    d = q;

    // conversion clock divider
    if (q.burst ? burst_osc_tick_in : 1'b1) begin
      if (q.div == 5'h00) begin
        d.div = q.divider;
        tick  = 1'b1;
      end else begin
        d.div = q.div - 5'h01;
      end
    end

    // start source select
    d.ext_prev = ext_conv_start_in;
    case (q.sel)
      SACS_SRC_SW:  start = wr_in && addr_in == SACS_CTRL && wdata_in[SACS_B_BUSY];
      SACS_SRC_T0:  start = timer0_ovf_in;
      SACS_SRC_T2:  start = timer2_split_in ? timer2_low_ovf_in : timer2_high_ovf_in;
      SACS_SRC_T3:  start = timer3_split_in ? timer3_low_ovf_in : timer3_high_ovf_in;
      SACS_SRC_EXT: start = ext_conv_start_in && !q.ext_prev;
      default:      start = 1'b0;
    endcase

    // software writes; hardware sets below win over clears
    if (wr_in) begin
      case (addr_in)
        SACS_CTRL: begin
          d.en    = wdata_in[SACS_B_EN];
          d.burst = wdata_in[SACS_B_BURST];
          d.sel   = wdata_in[2:0];
          if (!wdata_in[SACS_B_DONE]) begin
            d.done = 1'b0;
          end
          if (!wdata_in[SACS_B_WIN]) begin
            d.winf = 1'b0;
          end
        end
        SACS_CFG: begin
          d.divider = wdata_in[7:3];
          d.eightb  = wdata_in[SACS_B_EIGHT];
          d.lptrk   = wdata_in[SACS_B_LPTRK];
          d.gain    = wdata_in[SACS_B_GAIN];
        end
        SACS_ACC: begin
          d.die    = wdata_in[SACS_B_DIE];
          d.wie    = wdata_in[SACS_B_WIE];
          d.repsel = wdata_in[2:0];
        end
        SACS_TIME: begin
          d.pwr = wdata_in[7:4];
          d.trk = wdata_in[3:0];
        end
        SACS_WGT: d.gt = wdata_in;
        SACS_WLT: d.lt = wdata_in;
        default: ;
      endcase
    end

    // sequencer
    last = q.eightb ? SACS_LSB8 : SACS_LSB10;
    case (q.st)
      // idle: wait for a start from the picked source
      SACS_IDLE: begin
        if (start) begin
          d.busy = 1'b1;
          if (q.burst) begin
            if (!q.en) begin
              d.st  = SACS_PWRUP;
              d.cnt = {2'b00, q.pwr};
            end else begin
              d.st  = SACS_TRACK;
              d.cnt = {2'b00, q.trk};
            end
          end else if (q.lptrk && q.sel != SACS_SRC_EXT) begin
            d.st  = SACS_LPTRK;
            d.cnt = SACS_LP_TRACK;
          end else begin
            d.st   = SACS_CONV;
            d.bitn = SACS_MSB;
            d.sar  = SACS_SAR_INIT;
          end
        end
      end
      // waking a powered-down converter in burst mode
      SACS_PWRUP: begin
        if (tick) begin
          if (q.cnt == 6'h00) begin
            d.st  = SACS_TRACK;
            d.cnt = {2'b00, q.trk};
          end else begin
            d.cnt = q.cnt - 6'h01;
          end
        end
      end
      // burst tracking for the programmed time
      SACS_TRACK: begin
        if (tick) begin
          if (q.cnt != 6'h00) begin
            d.cnt = q.cnt - 6'h01;
          end else if (q.lptrk) begin
            d.st  = SACS_LPTRK;
            d.cnt = SACS_LP_TRACK;
          end else begin
            d.st   = SACS_CONV;
            d.bitn = SACS_MSB;
            d.sar  = SACS_SAR_INIT;
          end
        end
      end
      // fixed three-tick low-power tracking
      SACS_LPTRK: begin
        if (tick) begin
          if (q.cnt == 6'h00) begin
            d.st   = SACS_CONV;
            d.bitn = SACS_MSB;
            d.sar  = SACS_SAR_INIT;
          end else begin
            d.cnt = q.cnt - 6'h01;
          end
        end
      end
      // one trial bit per tick, msb first, then sum
      SACS_CONV: begin
        if (tick) begin
          sample          = q.sar;
          sample[q.bitn]  = sar_cmp_in;
          d.sar           = sample;
          if (q.bitn != last) begin
            d.sar[q.bitn - 4'h1] = 1'b1;
            d.bitn = q.bitn - 4'h1;
          end else begin
            rep_n = q.rep + 7'h01;
            d.acc = q.acc + {6'h00, sample};
            d.rep = rep_n;
            if (rep_n == sacs_target(q.repsel)) begin
              d.st   = SACS_IDLE;
              d.busy = 1'b0;
              d.done = 1'b1;
              d.resh = d.acc[15:8];
              d.resl = d.acc[7:0];
              d.acc  = 16'h0000;
              d.rep  = 7'h00;
              if (d.resh > q.gt || d.resh < q.lt) begin
                d.winf = 1'b1;
              end
            end else if (q.burst) begin
              d.st  = SACS_TRACK;
              d.cnt = {2'b00, q.trk};
            end else begin
              d.st   = SACS_IDLE;
              d.busy = 1'b0;
            end
          end
        end
      end
      default: d.st = SACS_IDLE;
    endcase

    // register reads, data one cycle later
    d.rdata = 8'h00;
    if (rd_in) begin
      case (addr_in)
        SACS_CTRL: d.rdata = {q.en, q.burst, q.done, q.busy, q.winf, q.sel};
        SACS_CFG:  d.rdata = {q.divider, q.eightb, q.lptrk, q.gain};
        SACS_ACC:  d.rdata = {q.die, q.wie, 3'h0, q.repsel};
        SACS_TIME: d.rdata = {q.pwr, q.trk};
        SACS_RESH: d.rdata = q.resh;
        SACS_RESL: d.rdata = q.eightb ? 8'h00 : q.resl;
        SACS_WGT:  d.rdata = q.gt;
        SACS_WLT:  d.rdata = q.lt;
        default:   d.rdata = 8'h00;
      endcase
    end

    // analog control outputs
    d.conv  = d.st == SACS_CONV;
    d.power = d.en || (d.burst && d.st != SACS_IDLE);
    d.track = !standby_in &&
              (d.st == SACS_TRACK || d.st == SACS_LPTRK ||
               (d.st == SACS_IDLE && !d.burst &&
                (!d.lptrk || (d.sel == SACS_SRC_EXT && !ext_conv_start_in))));
    d.irq   = (d.done && d.die) || (d.winf && d.wie);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register with clock enable
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      // everything zero, then the non-zero defaults
      q         <= '0;
      q.st      <= SACS_IDLE;
      q.div     <= SACS_DIV_RST;
      q.divider <= SACS_DIV_RST;
      q.pwr     <= SACS_TIME_RST[7:4];
      q.trk     <= SACS_TIME_RST[3:0];
      q.gt      <= 8'hff;
      q.bitn    <= SACS_MSB;
    end else if (ce_in) begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign rdata_out             = q.rdata;
  assign dac_code_out          = q.sar;
  assign track_out             = q.track;
  assign convert_out           = q.conv;
  assign power_out             = q.power;
  assign input_gain_select_out = q.gain;
  assign irq_out               = q.irq;
endmodule

// File: bench/sacs_ext_trigger.sv
// model of the external source driving the conversion start pin
`timescale 1ns/1ns
module sacs_ext_trigger #(
  parameter int LOW_CYC = 8
) (
  input  wire logic clk_in,
  input  wire logic fire_in,
  output logic      pin_out
);
  int   cnt = 0;
  logic low_q = 1'b0;
  assign pin_out = !low_q;
  // idle high; a request drops the pin, then raises it to start
  always @(posedge clk_in) begin
    if (fire_in) begin
      low_q <= 1'b1;
      cnt   <= LOW_CYC;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) low_q <= 1'b0;
    end
  end
endmodule

// File: bench/sacs_sequencer_chk.sv
// port assertions for the conversion sequencer
`timescale 1ns/1ns
module sacs_sequencer_chk (
  input wire logic       clk_in,
  input wire logic       reset_in,
  input wire logic       wr_in,
  input wire logic       standby_in,
  input wire logic [9:0] dac_code_out,
  input wire logic       track_out,
  input wire logic       convert_out,
  input wire logic       power_out,
  input wire logic       irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  ////////////////////////////////////////////////////////////////////////////
  a_standby_no_track: assert property (standby_in && $past(standby_in) |-> !track_out)
    else $error("tracking in standby");
  a_convert_no_track: assert property (convert_out |-> !track_out)
    else $error("tracking while converting");
  a_first_trial: assert property ($rose(convert_out) |-> dac_code_out == 10'h200)
    else $error("first trial code wrong");
  a_convert_min_len: assert property ($rose(convert_out) |-> convert_out[*7])
    else $error("conversion too short");
  a_convert_ends: assert property ($rose(convert_out) |-> ##[1:1000] !convert_out)
    else $error("conversion never ends");
  a_powered_convert: assert property (convert_out |-> power_out)
    else $error("converting while powered down");
  a_irq_clear_write: assert property ($fell(irq_out) |-> $past(wr_in) || $past(wr_in, 2))
    else $error("irq dropped without a write");
  a_irq_rise_cause: assert property ($rose(irq_out) |->
    $past(convert_out) || $past(convert_out, 2) || $past(wr_in) || $past(wr_in, 2))
    else $error("irq rose without completion");
endmodule
bind sacs_sequencer sacs_sequencer_chk u_chk (.clk_in(clk_in), .reset_in(reset_in),
  .wr_in(wr_in), .standby_in(standby_in), .dac_code_out(dac_code_out),
  .track_out(track_out), .convert_out(convert_out), .power_out(power_out), .irq_out(irq_out));

// File: bench/sacs_sequencer_bench.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ns
module sacs_sequencer_bench;
  import sacs_pkg::*;
  logic       clk_in, reset_in, wr, rd, sby, tick;
  logic [2:0] addr;
  logic [7:0] wdata, ctl, cfg, wgt, wlt, v;
  logic [5:0] tmr;
  logic [1:0] split;
  logic [9:0] vin;
  wire  [7:0] rdata;
  wire  [9:0] dac;
  wire        track, conv, pwr, irq, pin, gain;
  int         n_errors = 0;
  int         n_compared = 0;
  ////////////////////////////////////////////////////////////////////////////
  sacs_sequencer u_sacs_sequencer (.clk_in(clk_in), .reset_in(reset_in), .ce_in(1'b1),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .timer0_ovf_in(tmr[0]), .timer2_low_ovf_in(tmr[1]), .timer2_high_ovf_in(tmr[2]),
    .timer2_split_in(split[0]), .timer3_low_ovf_in(tmr[3]), .timer3_high_ovf_in(tmr[4]),
    .timer3_split_in(split[1]), .ext_conv_start_in(pin), .standby_in(sby),
    .burst_osc_tick_in(tick), .sar_cmp_in(vin >= dac), .dac_code_out(dac),
    .track_out(track), .convert_out(conv), .power_out(pwr), .input_gain_select_out(gain),
    .irq_out(irq));
  sacs_ext_trigger u_sacs_ext_trigger (.clk_in(clk_in), .fire_in(tmr[5]), .pin_out(pin));
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (n_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge clk_in) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a);
    @(posedge clk_in) begin addr <= a; rd <= 1'b1; end
    @(posedge clk_in) rd <= 1'b0;
    @(negedge clk_in) v = rdata;
  endtask
  task automatic pulse(input int i);
    @(posedge clk_in) tmr[i] <= 1'b1;
    @(posedge clk_in) tmr <= '0;
  endtask
  // n conversions summed; trig < 0 is a software start, else a pulse index
  task automatic run(input int n, input int trig, input int starts);
    logic [15:0] s;
    s = 16'(n * (cfg[2] ? (vin & 10'h3fc) : vin));
    for (int i = 0; i < starts; i++) begin
      if (trig >= 0) pulse(trig);
      else wr_reg(SACS_CTRL, ctl | 8'h10);
      if (trig < 0 && !ctl[6]) wr_reg(SACS_CTRL, ctl | 8'h10);
      if (trig == 5 && !ctl[6]) repeat (3) @(negedge clk_in);
      if (trig == 5 && !ctl[6]) chk("pin low track", 16'h1, 16'(track));
      for (int k = 0; k < 1000 && (k == 0 || v[4] !== 1'b0); k++) rd_reg(SACS_CTRL);
      if (i < starts - 1) chk("early flags", 16'h0, 16'(v[5] | v[3]));
    end
    for (int k = 0; k < 1000 && v[5] !== 1'b1; k++) rd_reg(SACS_CTRL);
    chk("done", 16'h1, 16'(v[5]));
    chk("window", 16'((s[15:8] > wgt) || (s[15:8] < wlt)), 16'(v[3]));
    chk("irq", 16'h1, 16'(irq));
    chk("gain", 16'(cfg[0]), 16'(gain));
    rd_reg(SACS_RESH);
    chk("result high", 16'(s[15:8]), 16'(v));
    rd_reg(SACS_RESL);
    chk("result low", cfg[2] ? 16'h0 : 16'(s[7:0]), 16'(v));
    rd_reg(SACS_CTRL);
    chk("done held", 16'h1, 16'(v[5]));
    if (ctl[6]) chk("burst idle power", 16'(ctl[7]), 16'(pwr));
    wr_reg(SACS_CTRL, ctl);
    rd_reg(SACS_CTRL);
    chk("done cleared", 16'h0, 16'(v[5]));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // clock and random burst oscillator edges
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  always @(posedge clk_in) tick <= 1'($urandom % 2);
  // watchdog
  initial begin
    repeat (60000) @(posedge clk_in);
    n_errors++;
    conclude();
  end
  // main sequence
  initial begin
    void'($urandom(32'h30093609));
    {wr, rd, sby, tmr, addr, wdata, split, vin, ctl, cfg, wlt} = '0;
    wgt = 8'hff;
    reset_in = 1'b1;
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b0;
    rd_reg(SACS_CFG);
    chk("cfg reset", 16'hf8, 16'(v));
    rd_reg(SACS_TIME);
    chk("time reset", 16'h11, 16'(v));
    chk("idle track", 16'h1, 16'(track));
    @(posedge clk_in) sby <= 1'b1;
    repeat (3) @(negedge clk_in);
    chk("standby track", 16'h0, 16'(track));
    @(posedge clk_in) sby <= 1'b0;
    // software starts, ten then eight bit with low-power tracking
    cfg = 8'h08;
    wr_reg(SACS_CFG, cfg);
    wr_reg(SACS_WLT, wlt);
    wr_reg(SACS_ACC, 8'h80);
    ctl = 8'h80;
    wr_reg(SACS_CTRL, ctl);
    vin = 10'($urandom);
    run(1, -1, 1);
    cfg = 8'h0f;
    wr_reg(SACS_CFG, cfg);
    vin = 10'($urandom);
    run(1, -1, 1);
    // timer sources, repeat four, each conversion its own start
    cfg = 8'h08;
    wr_reg(SACS_CFG, cfg);
    wr_reg(SACS_ACC, 8'h81);
    for (int j = 1; j < 4; j++) begin
      split = 2'($urandom);
      ctl = 8'h80 | 8'(j);
      wgt = 8'($urandom % 16);
      wlt = 8'($urandom % 16);
      wr_reg(SACS_WGT, wgt);
      wr_reg(SACS_WLT, wlt);
      wr_reg(SACS_CTRL, ctl);
      if (j > 1) pulse(split[j-2] ? 2 * j - 2 : 2 * j - 3);
      rd_reg(SACS_CTRL);
      chk("wrong overflow", 16'h0, 16'(v[4]));
      vin = 10'($urandom);
      run(4, j == 1 ? 0 : (split[j-2] ? 2 * j - 3 : 2 * j - 2), 4);
    end
    // external pin with low-power tracking
    cfg = 8'h0a;
    wr_reg(SACS_CFG, cfg);
    wr_reg(SACS_ACC, 8'h80);
    ctl = 8'h84;
    wr_reg(SACS_CTRL, ctl);
    vin = 10'($urandom);
    run(1, 5, 1);
    // bursts of eight, powered down then kept enabled
    wr_reg(SACS_ACC, 8'h82);
    ctl = 8'h40;
    wr_reg(SACS_CTRL, ctl);
    vin = 10'($urandom);
    run(8, -1, 1);
    ctl = 8'hc4;
    wr_reg(SACS_CTRL, ctl);
    vin = 10'($urandom);
    run(8, 5, 1);
    conclude();
  end
endmodule
